// ---- core/pcc_channel.v ----
`timescale 1ns/10ps
`include "pcc_regs.vh"

// Behaviour
// - Capture mode: selected pin edge copies counter into 16-bit compare register.
// - Every capture sets event flag; irq only if enabled; only software clears.
// - With both edges selected, pin level stays readable at a port.
// - Software timer: flag set whenever counter equals compare register.
// - Low-byte write clears comparator enable; high-byte write sets it; auto-reload writes leave it unchanged.
// - High-speed output with match enable: each 16-bit match toggles pin and sets flag.
// - High-speed output with comparator off: pin out bit holds level, no toggle; pin enable drops, pin undriven.
// - Frequency output: low-byte match toggles pin, adds high byte to low.
// - Frequency output: high byte zero means 256 clocks between toggles.
// - Frequency output with match enable: flag on full 16-bit equality.
// - 8-bit PWM: pin high on low-byte match, low on low-byte overflow.
// - 8-bit PWM: low byte reloaded from high byte at each wrap.
// - 8-bit PWM needs length 00; match enable sets flag on match.
// - 8-bit PWM: intermediate overflow flag set at every low-byte overflow.
// - 8 to 11-bit PWM share one length setting; other modes independent.
// - Comparator off: no toggling, every PWM output held low.
// - Mode decode from mode bits 5..1 as tabulated; bit 7 marks 16-bit PWM.
// - 16-bit PWM: bit 7 plus pulse bit; length field ignored.
// - Length field picks 8..11 bits; select bit chooses auto-reload access.
// - Mode bit 0 enables event irq; config bit 5 enables overflow irq.
module pcc_channel #(
    parameter CNT_W = 16
) (
    input  wire             clk_sys,
    input  wire             reset_n,
    input  wire [CNT_W-1:0] counter_value,
    input  wire             counter_tick,
    input  wire             mode_wr,
    input  wire [7:0]       mode_wdata,
    input  wire             cfg_wr,
    input  wire [7:0]       cfg_wdata,
    input  wire             low_wr,
    input  wire             high_wr,
    input  wire [7:0]       byte_wdata,
    input  wire             flag_wr,
    input  wire             flag_wdata,
    input  wire             ovf_flag_wr,
    input  wire             ovf_flag_wdata,
    input  wire             channel_pin_in,
    output wire [7:0]       mode_rdata,
    output wire [7:0]       cfg_rdata,
    output wire [7:0]       low_rdata,
    output wire [7:0]       high_rdata,
    output reg              channel_pin_out,
    output wire             channel_pin_oe,
    output wire             pin_level,
    output reg              channel_event_flag,
    output reg              intermediate_overflow_flag,
    output wire             channel_irq,
    output wire             overflow_irq
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [7:0]       mode_q;
    reg  [7:0]       cfg_q;
    reg  [CNT_W-1:0] ccr_q;
    reg              sync1_q;
    reg              sync2_q;
    reg              sync3_q;
    reg  [CNT_W-1:0] cnt_prev_q;
    reg              ar_rd_idx_q;
    wire [7:0]       ar_rdata;
    wire [CNT_W-1:0] ar_word;

    wire cmp_en   = mode_q[`PCC_MODE_CMP_EN];
    wire cap_rise = mode_q[`PCC_MODE_CAP_RISE];
    wire cap_fall = mode_q[`PCC_MODE_CAP_FALL];
    wire mat_en   = mode_q[`PCC_MODE_MATCH_EN];
    wire tog_en   = mode_q[`PCC_MODE_TOGGLE_EN];
    wire pwm_en   = mode_q[`PCC_MODE_PULSE_EN];
    wire pwm16    = mode_q[`PCC_MODE_PWM16];
    wire [1:0] len_sel = cfg_q[`PCC_CFG_LEN_HI:`PCC_CFG_LEN_LO];
    wire ar_sel   = cfg_q[`PCC_CFG_ARSEL];

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    wire mode_capture = (cap_rise | cap_fall) & ~tog_en & ~pwm_en;
    wire mode_timer   = mat_en & ~tog_en & ~pwm_en & ~cap_rise & ~cap_fall;
    wire mode_hso     = tog_en & ~pwm_en & ~cap_rise & ~cap_fall;
    wire mode_freq    = tog_en & pwm_en & ~cap_rise & ~cap_fall;
    wire mode_pwm16   = pwm16 & pwm_en & ~tog_en & ~cap_rise & ~cap_fall;
    wire mode_pulse_mod_enable    = ~pwm16 & pwm_en & ~tog_en & ~cap_rise & ~cap_fall;
    wire mode_pwm8    = mode_pulse_mod_enable & (len_sel == `PCC_LEN_8);

    // ****************************************************************
    // Input synchroniser and edge detect
    // ****************************************************************
    // Pulses under one clock may be lost; the driver must respect that.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= channel_pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    wire rise_edge = sync2_q & ~sync3_q;
    wire fall_edge = ~sync2_q & sync3_q;
    wire capture_ev = mode_capture & ((cap_rise & rise_edge) | (cap_fall & fall_edge));
    assign pin_level = sync2_q;

    // ****************************************************************
    // Counter events, evaluated once per counter tick
    // ****************************************************************
    // N-bit overflow: counter bit N-1..0 wrapped to zero on this tick
    reg [10:0] len_mask;
    always @* begin
        case (len_sel)
            `PCC_LEN_8:  len_mask = 11'h0ff;
            `PCC_LEN_9:  len_mask = 11'h1ff;
            `PCC_LEN_10: len_mask = 11'h3ff;
            `PCC_LEN_11: len_mask = 11'h7ff;
            default:     len_mask = 11'h0ff;
        endcase
    end
    wire [10:0] cnt_low_n = counter_value[10:0] & len_mask;
    wire [10:0] ccr_low_n = ccr_q[10:0] & len_mask;
    wire cnt_moved  = counter_value != cnt_prev_q;
    wire evt        = counter_tick & cnt_moved;
    wire full_match = evt & (counter_value == ccr_q);
    wire low_match  = evt & (counter_value[7:0] == ccr_q[7:0]);
    wire n_match    = evt & (cnt_low_n == ccr_low_n);
    wire low_ovf    = evt & (counter_value[7:0] == `PCC_RESET_BYTE);
    wire n_ovf      = evt & (cnt_low_n == 11'h000);
    wire full_ovf   = evt & (counter_value == `PCC_RESET_WORD);

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_prev_q <= `PCC_RESET_WORD;
        end else if (counter_tick) begin
            cnt_prev_q <= counter_value;
        end
    end

    // ****************************************************************
    // Mode and config registers
    // ****************************************************************
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `PCC_RESET_MODE;
        end else if (mode_wr) begin
            mode_q <= mode_wdata;
        end else if (low_wr && !(mode_pulse_mod_enable && !mode_pwm8 && ar_sel)) begin
            mode_q[`PCC_MODE_CMP_EN] <= 1'b0;
        end else if (high_wr && !(mode_pulse_mod_enable && !mode_pwm8 && ar_sel)) begin
            mode_q[`PCC_MODE_CMP_EN] <= 1'b1;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= `PCC_RESET_MODE;
        end else if (cfg_wr) begin
            cfg_q <= cfg_wdata;
        end
    end

    // ****************************************************************
    // Auto-reload store for 9..11-bit PWM
    // ****************************************************************
    wire ar_access = ar_sel & mode_pulse_mod_enable & ~mode_pwm8;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ar_rd_idx_q <= `PCC_IDX_LOW;
        end else begin
            ar_rd_idx_q <= ~ar_rd_idx_q;
        end
    end
    pcc_word_store #(.WIDTH(8)) u_reload (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .wr_en     (ar_access & (low_wr | high_wr)),
        .wr_idx    (high_wr ? `PCC_IDX_HIGH : `PCC_IDX_LOW),
        .wr_data   (byte_wdata),
        .rd_idx    (ar_rd_idx_q),
        .rd_data_q (),
        .word      (ar_word)
    );
    assign ar_rdata = 8'h00;

    // ****************************************************************
    // Capture/compare register
    // ****************************************************************
    wire [7:0] half_period = ccr_q[15:8]; // Zero wraps the 8-bit add to 256.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ccr_q <= `PCC_RESET_WORD;
        end else if (low_wr && !ar_access) begin
            ccr_q[7:0] <= byte_wdata;
        end else if (high_wr && !ar_access) begin
            ccr_q[15:8] <= byte_wdata;
        end else if (capture_ev) begin
            ccr_q <= counter_value;
        end else if (mode_freq && cmp_en && low_match) begin
            ccr_q[7:0] <= ccr_q[7:0] + half_period;
        end else if (mode_pwm8 && low_ovf) begin
            ccr_q[7:0] <= ccr_q[15:8];
        end else if (mode_pulse_mod_enable && !mode_pwm8 && n_ovf) begin
            ccr_q <= ar_word & {5'b00000, len_mask};
        end
    end

    // ****************************************************************
    // Pin output
    // ****************************************************************
    wire pwm_any = mode_pulse_mod_enable | mode_pwm16;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            channel_pin_out <= 1'b0;
        end else if (pwm_any && !cmp_en) begin
            channel_pin_out <= 1'b0;
        end else if (mode_hso && cmp_en && mat_en && full_match) begin
            channel_pin_out <= ~channel_pin_out;
        end else if (mode_freq && cmp_en && low_match) begin
            channel_pin_out <= ~channel_pin_out;
        end else if (mode_pwm8) begin
            if (low_ovf) begin
                channel_pin_out <= 1'b0;
            end else if (low_match) begin
                channel_pin_out <= 1'b1;
            end
        end else if (mode_pulse_mod_enable) begin
            if (n_ovf) begin
                channel_pin_out <= 1'b0;
            end else if (n_match) begin
                channel_pin_out <= 1'b1;
            end
        end else if (mode_pwm16) begin
            if (full_ovf) begin
                channel_pin_out <= 1'b0;
            end else if (full_match) begin
                channel_pin_out <= 1'b1;
            end
        end
    end
    assign channel_pin_oe = cmp_en & (mode_hso | mode_freq | pwm_any) | (pwm_any & ~cmp_en);

    // ****************************************************************
    // Flags: hardware set wins over a software clear
    // ****************************************************************
    wire pwm_match = (mode_pwm8 & low_match) | (mode_pulse_mod_enable & ~mode_pwm8 & n_match) | (mode_pwm16 & full_match);
    wire set_event = capture_ev
                   | (mode_timer & cmp_en & full_match)
                   | (mode_hso & cmp_en & mat_en & full_match)
                   | (mode_freq & cmp_en & mat_en & full_match)
                   | (pwm_any & cmp_en & mat_en & pwm_match);
    wire set_ovf = mode_pulse_mod_enable & n_ovf;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            channel_event_flag         <= 1'b0;
            intermediate_overflow_flag <= 1'b0;
        end else begin
            if (set_event) begin
                channel_event_flag <= 1'b1;
            end else if (flag_wr) begin
                channel_event_flag <= flag_wdata;
            end
            if (set_ovf) begin
                intermediate_overflow_flag <= 1'b1;
            end else if (ovf_flag_wr) begin
                intermediate_overflow_flag <= ovf_flag_wdata;
            end
        end
    end

    assign channel_irq  = channel_event_flag & mode_q[`PCC_MODE_IRQ_EN];
    assign overflow_irq = intermediate_overflow_flag & cfg_q[`PCC_CFG_OVF_IRQ_EN];

    // ****************************************************************
    // Read back
    // ****************************************************************
    assign mode_rdata = mode_q;
    assign cfg_rdata  = cfg_q;
    assign low_rdata  = ar_access ? ar_word[7:0] : ccr_q[7:0];
    assign high_rdata = ar_access ? ar_word[15:8] : ccr_q[15:8];
endmodule // pcc_channel

// ---- include/pcc_regs.vh ----
`ifndef PCC_REGS_VH
`define PCC_REGS_VH
// Mode register bit positions
`define PCC_MODE_PWM16      7
`define PCC_MODE_CMP_EN     6
`define PCC_MODE_CAP_RISE   5
`define PCC_MODE_CAP_FALL   4
`define PCC_MODE_MATCH_EN   3
`define PCC_MODE_TOGGLE_EN  2
`define PCC_MODE_PULSE_EN   1
`define PCC_MODE_IRQ_EN     0
// Length config bit positions
`define PCC_CFG_ARSEL       7
`define PCC_CFG_OVF_IRQ_EN  5
`define PCC_CFG_LEN_HI      1
`define PCC_CFG_LEN_LO      0
// Reset values
`define PCC_RESET_BYTE      8'h00
`define PCC_RESET_WORD      16'h0000
`define PCC_RESET_MODE      8'h00
`define PCC_LOW_MAX         8'hff
// Cycle length codes
`define PCC_LEN_8           2'b00
`define PCC_LEN_9           2'b01
`define PCC_LEN_10          2'b10
`define PCC_LEN_11          2'b11
// Register file indices
`define PCC_IDX_LOW         1'b0
`define PCC_IDX_HIGH        1'b1
`endif

// ---- core/pcc_word_store.v ----
`timescale 1ns/10ps
// Two-byte store with registered read data; used for the auto-reload value.
module pcc_word_store #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys,
    input  wire             reset_n,
    input  wire             wr_en,
    input  wire             wr_idx,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             rd_idx,
    output reg  [WIDTH-1:0] rd_data_q,
    output wire [2*WIDTH-1:0] word
);
    reg [WIDTH-1:0] mem_q [0:1];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_entry
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    mem_q[g] <= {WIDTH{1'b0}};
                end else if (wr_en && (wr_idx == g)) begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= {WIDTH{1'b0}};
        end else begin
            rd_data_q <= mem_q[rd_idx];
        end
    end

    assign word = {mem_q[1], mem_q[0]};
endmodule // pcc_word_store

// ---- verification/pcc_channel_chk.sv ----
`timescale 1ns/10ps
module pcc_channel_chk #(parameter CNT_W = 16) (
    input wire             clk_sys, reset_n, counter_tick, mode_wr, low_wr, high_wr, flag_wr,
    input wire [CNT_W-1:0] counter_value,
    input wire [7:0]       mode_rdata, cfg_rdata, low_rdata, high_rdata,
    input wire             channel_pin_in, pin_level, channel_event_flag, intermediate_overflow_flag,
    input wire             channel_irq, overflow_irq, channel_pin_out
);
    // ****************************************
    // Counter event helpers
    // ****************************************
    reg  [CNT_W-1:0] prev_q;
    wire             ev  = counter_tick && counter_value != prev_q;
    wire             hit = counter_value == {high_rdata, low_rdata};
    wire             pwm8 = mode_rdata[7:1] == 7'b0100101 && cfg_rdata[1:0] == 2'b00 && low_rdata != 8'h00;
    always @(posedge clk_sys or negedge reset_n)
        if (!reset_n) prev_q <= {CNT_W{1'b0}};
        else if (counter_tick) prev_q <= counter_value;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    timer_flag_a: assert property (mode_rdata[6:1] == 6'b100100 && ev && hit |=> channel_event_flag)
        else $error("timer match left flag clear");
    low_clear_a: assert property (low_wr && !mode_wr && !cfg_rdata[7] |=> !mode_rdata[6])
        else $error("low byte write kept comparator on");
    high_set_a: assert property (high_wr && !low_wr && !mode_wr && !cfg_rdata[7] |=> mode_rdata[6])
        else $error("high byte write left comparator off");
    flag_sticky_a: assert property (channel_event_flag && !flag_wr |=> channel_event_flag)
        else $error("event flag cleared without write");
    irq_gate_a: assert property (channel_irq == (channel_event_flag && mode_rdata[0]) &&
        overflow_irq == (intermediate_overflow_flag && cfg_rdata[5])) else $error("irq gating wrong");
    hs_toggle_a: assert property (mode_rdata[6:1] == 6'b100110 && ev && hit |=>
        channel_pin_out != $past(channel_pin_out) && channel_event_flag) else $error("no toggle on match");
    hs_hold_a: assert property (mode_rdata[6:1] == 6'b000110 && !mode_wr |=> $stable(channel_pin_out))
        else $error("pin moved with comparator off");
    pwm_off_a: assert property (mode_rdata[7:4] == 4'h0 && mode_rdata[2:1] == 2'b01 |=> !channel_pin_out)
        else $error("pwm output high with comparator off");
    pwm_rise_a: assert property (pwm8 && ev && counter_value[7:0] == low_rdata |=>
        channel_pin_out && channel_event_flag) else $error("pwm match did not raise pin");
    pwm_fall_a: assert property (pwm8 && ev && counter_value[7:0] == 8'h00 |=>
        !channel_pin_out && intermediate_overflow_flag) else $error("pwm overflow did not drop pin");
    pin_sync_a: assert property (pin_level == $past(channel_pin_in, 2))
        else $error("pin level latency wrong");
endmodule // pcc_channel_chk
bind pcc_channel pcc_channel_chk #(.CNT_W(CNT_W)) chk (.clk_sys, .reset_n, .counter_tick, .mode_wr, .low_wr,
    .high_wr, .flag_wr, .counter_value, .mode_rdata, .cfg_rdata, .low_rdata, .high_rdata, .channel_pin_in,
    .pin_level, .channel_event_flag, .intermediate_overflow_flag, .channel_irq, .overflow_irq, .channel_pin_out);

// ---- verification/pcc_pin_model.sv ----
`timescale 1ns/10ps
module pcc_pin_model (
    input  wire clk_sys,
    input  wire want,
    input  wire pin_out,
    input  wire pin_oe,
    output wire pin_wire
);
    reg       lvl_q = 1'b0;
    reg [1:0] held_q = 2'b00;
    // A new level waits until the old one has stood two clocks
    always @(posedge clk_sys) begin
        if (want != lvl_q && held_q >= 2'd1) begin
            lvl_q <= want;
            held_q <= 2'd0;
        end else if (held_q != 2'd3)
            held_q <= held_q + 2'd1;
    end
    assign pin_wire = pin_oe ? pin_out : lvl_q;
endmodule // pcc_pin_model

// ---- verification/test_counter_array_capture_compare_module.sv ----
`timescale 1ns/10ps
module test_counter_array_capture_compare_module;
    reg        clk_sys = 0, reset_n = 0, run = 0, want = 0, prev_pin = 0, cap;
    reg [15:0] counter_value = 16'h0000, prev_cv = 16'h0000, v, old;
    reg [5:0]  wr = 6'h00;
    reg [7:0]  wd = 8'h00, lo, hi, m;
    wire       channel_pin_in, channel_pin_out, channel_pin_oe, pin_level, ev_flag, ovf_flag, ev_irq, ovf_irq;
    wire [7:0] mode_rdata, cfg_rdata, low_rdata, high_rdata;
    integer    bad_count = 0, samples_checked = 0, seed = 46542;
    integer    tog = 0, exp_tog = 0, hi_cnt = 0, ml = 0, hb = 0, i, k;
    pcc_channel uut (.clk_sys, .reset_n, .counter_value, .counter_tick(1'b1), .mode_wr(wr[0]), .mode_wdata(wd),
        .cfg_wr(wr[1]), .cfg_wdata(wd), .low_wr(wr[2]), .high_wr(wr[3]), .byte_wdata(wd), .flag_wr(wr[4]),
        .flag_wdata(wd[0]), .ovf_flag_wr(wr[5]), .ovf_flag_wdata(wd[0]), .channel_pin_in, .mode_rdata,
        .cfg_rdata, .low_rdata, .high_rdata, .channel_pin_out, .channel_pin_oe, .pin_level,
        .channel_event_flag(ev_flag), .intermediate_overflow_flag(ovf_flag), .channel_irq(ev_irq),
        .overflow_irq(ovf_irq));
    pcc_pin_model far (.clk_sys, .want, .pin_out(channel_pin_out), .pin_oe(channel_pin_oe), .pin_wire(channel_pin_in));
    initial forever #2 clk_sys = ~clk_sys;
    // ****************************************
    // Counter drive and reference model
    // ****************************************
    always @(posedge clk_sys) begin
        if (run) counter_value <= counter_value + 16'h0001;
        if (channel_pin_out !== prev_pin) tog = tog + 1;
        if (channel_pin_out === 1'b1) hi_cnt = hi_cnt + 1;
        // Frequency model: each low-byte hit moves the target on by the half period
        if (counter_value !== prev_cv && counter_value[7:0] == ml[7:0]) begin
            exp_tog = exp_tog + 1;
            ml = ml + hb;
        end
        prev_pin = channel_pin_out;
        prev_cv = counter_value;
    end
    task chk(input [8*8-1:0] nm, input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task w(input integer b, input [7:0] d);
        begin
            @(posedge clk_sys); wr <= 6'h01 << b; wd <= d;
            @(posedge clk_sys); wr <= 6'h00; #1;
        end
    endtask
    task sweep(input [15:0] s, input integer n);
        begin
            @(posedge clk_sys); counter_value <= s; run <= 1;
            repeat (n) @(posedge clk_sys);
            run <= 0;
            repeat (3) @(posedge clk_sys);
            #1;
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        bad_count = bad_count + 1;
        summarize;
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys); #1;
        chk("mode", mode_rdata, 0);
        chk("flag", ev_flag, 0);
        lo = $random(seed); hi = $random(seed);
        w(2, lo); chk("cmp_lo", mode_rdata[6], 0);
        w(3, hi); chk("cmp_hi", mode_rdata[6], 1);
        chk("ccr", {high_rdata, low_rdata}, {hi, lo});
        w(0, 8'h49); sweep({hi, lo} - 16'h0005, 3); chk("t_early", ev_flag, 0);
        sweep({hi, lo} - 16'h0002, 6); chk("t_match", ev_flag, 1); chk("t_irq", ev_irq, 1);
        w(4, 8'h00); chk("t_clr", ev_flag, 0); chk("t_noirq", ev_irq, 0);
        w(0, 8'h4C); tog = 0;
        sweep({hi, lo} - 16'h0002, 6); chk("hs_tog", tog, 1); chk("hs_oe", channel_pin_oe, 1);
        w(2, lo); tog = 0;
        sweep({hi, lo} - 16'h0002, 6); chk("hs_hold", tog, 0);
        for (k = 0; k < 2; k = k + 1) begin
            lo = $random(seed); hi = k ? 8'h00 : {$random(seed)} % 60 + 5;
            w(2, lo); w(3, hi); w(0, 8'h46);
            ml = lo; hb = hi; tog = 0; exp_tog = 0;
            sweep($random(seed), 600); chk("f_tog", tog, exp_tog);
            chk("f_low", low_rdata, ml[7:0]);
        end
        lo = {$random(seed)} % 200 + 20; hi = {$random(seed)} % 200 + 20;
        w(1, 8'h20); chk("cfg", cfg_rdata, 8'h20);
        w(0, 8'h0A); w(2, lo); w(3, hi); w(4, 8'h00); hi_cnt = 0;
        sweep(16'h0001, 511); chk("p_duty", hi_cnt, 512 - lo - hi);
        chk("p_reload", low_rdata, hi);
        chk("p_flag", ev_flag, 1);
        chk("p_ovf", ovf_flag, 1); chk("p_ovfirq", ovf_irq, 1);
        w(5, 8'h00); chk("p_ovfclr", ovf_flag, 0);
        w(2, lo); hi_cnt = 0;
        sweep(16'h0001, 300); chk("p_off", hi_cnt, 0);
        w(0, 8'h8A); w(2, lo); w(3, hi); w(4, 8'h00);
        chk("p16_low", channel_pin_out, 0);
        sweep({hi, lo} - 16'h0002, 6); chk("p16_pin", channel_pin_out, 1);
        chk("p16_flag", ev_flag, 1);
        w(1, 8'h81); w(0, 8'h42); lo = $random(seed); hi = $random(seed);
        w(2, lo); w(3, hi); chk("ar_word", {high_rdata, low_rdata}, {hi, lo});
        chk("ar_cmp", mode_rdata[6], 1);
        for (k = 0; k < 3; k = k + 1) begin
            m = (k == 0) ? 8'h20 : (k == 1) ? 8'h10 : 8'h30;
            w(0, m);
            for (i = 0; i < 2; i = i + 1) begin
                v = $random(seed);
                @(posedge clk_sys); counter_value <= v;
                w(4, 8'h00); old = {high_rdata, low_rdata};
                @(posedge clk_sys); want <= ~want; cap = i ? m[4] : m[5];
                repeat (8) @(posedge clk_sys);
                #1;
                chk("c_flag", ev_flag, cap);
                chk("c_ccr", {high_rdata, low_rdata}, cap ? v : old);
                chk("c_level", pin_level, want);
            end
        end
        summarize;
    end
endmodule // test_counter_array_capture_compare_module
